// ### rtl/ain_defs.svh
`ifndef AIN_DEFS_SVH
`define AIN_DEFS_SVH
// Module clock rate in MHz; a time in microseconds times this is a cycle count.
`define CLK_MHZ 25
// Scan period with no event processing, in microseconds.
`define SCAN_BASE_US 1000
// Scan lengthening per channel with event processing, in microseconds.
`define EVT_EXTRA_US 150
// Standardized full scale.
`define STD_FULL 10000
// Largest magnitude of a user-scaling limit.
`define USER_LIM_MAX 30000
// Largest accepted alignment deviation.
`define ALIGN_DEV_MAX 1000
// Converter codes are fractions of 2**15.
`define RAW_SHIFT 15
`define RAW_HALF 32768
// Cause bit positions, shared by mask and source words.
`define CAUSE_RISE0 0
`define CAUSE_FALL0 1
`define CAUSE_RISE1 2
`define CAUSE_FALL1 3
// Aligned indicator position in the status word.
`define ALIGNED_BIT 0
// Reset values.
`define MASK_RST 16'h0000
`define SRC_RST 16'h0000
`define STATUS_RST 16'h0000
`endif

// ### rtl/ain_pkg.sv
package ain_pkg;
   // Scaling modes; bit 0 marks a bipolar range.
   typedef enum logic [1:0] {
      SCALE_STD_UNI = 2'b00,
      SCALE_STD_BI = 2'b01,
      SCALE_USER_UNI = 2'b10,
      SCALE_USER_BI = 2'b11
   } scale_mode_t;
   // Targets of a program write.
   typedef enum logic [2:0] {
      WR_MASK = 3'b000,
      WR_USER_LO = 3'b001,
      WR_USER_HI = 3'b010,
      WR_ALIGN = 3'b011,
      WR_UNALIGN = 3'b100
   } wr_sel_t;
   // Per-channel configuration held by the exchange.
   typedef struct packed {
      logic evt_en;
      logic [5:0] evt_num;
      scale_mode_t mode;
      logic signed [15:0] first_threshold;
      logic signed [15:0] second_threshold;
   } chan_cfg_t;
   // One program write.
   typedef struct packed {
      logic valid;
      wr_sel_t sel;
      logic [1:0] chan;
      logic [15:0] data;
   } prog_wr_t;
   // One converter sample, a signed fraction of 2**15.
   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic signed [16:0] raw;
   } sample_t;
   // One raised event.
   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic [5:0] num;
   } event_t;
endpackage

// ### rtl/analog_input_threshold_scaling.sv
`timescale 1ns/10ps
`include "ain_defs.svh"
module analog_input_threshold_scaling #(
   parameter int NUM_CHANNELS = 4,
   parameter int SCAN_BASE_CYC = `SCAN_BASE_US * `CLK_MHZ,
   parameter int EVT_EXTRA_CYC = `EVT_EXTRA_US * `CLK_MHZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Converter sample stream
   input wire ain_pkg::sample_t sample,
   // Channel configuration
   input wire ain_pkg::chan_cfg_t [NUM_CHANNELS-1:0] cfg,
   // Program write port
   input wire ain_pkg::prog_wr_t prog_wr,
   output logic wr_refused,
   // Exchange words per channel
   output logic [NUM_CHANNELS-1:0][15:0] meas_word,
   output logic [NUM_CHANNELS-1:0][15:0] event_source_word,
   output logic [NUM_CHANNELS-1:0][15:0] status_word,
   output logic [NUM_CHANNELS-1:0][15:0] cause_mask_word,
   // Events and scan timing
   output ain_pkg::event_t evt,
   output logic scan_start
);
   import ain_pkg::*;

   localparam int SCAN_W = $clog2(SCAN_BASE_CYC + NUM_CHANNELS * EVT_EXTRA_CYC + 1);

   // Channel fields are two bits wide; the base count must be at least 2 and the extra count not negative.
   if (NUM_CHANNELS < 1 || NUM_CHANNELS > 4 || SCAN_BASE_CYC < 2 || EVT_EXTRA_CYC < 0)
   begin : g_bad_params
      $error("Unsupported channel count or scan timing.");
   end

   // Saturate a wide result to a signed exchange word.
   function automatic logic [15:0] sat16(input logic signed [17:0] v);
      if (v > 18'sh07fff)
         return 16'h7fff;
      else if (v < -18'sh08000)
         return 16'h8000;
      else
         return v[15:0];
   endfunction

   logic signed [15:0] user_lo [NUM_CHANNELS]; // Accepted lower user limit.
   logic signed [15:0] user_hi [NUM_CHANNELS]; // Accepted upper user limit.
   logic signed [15:0] offset [NUM_CHANNELS]; // Alignment offset.
   logic signed [15:0] base_meas [NUM_CHANNELS]; // Last value before offset.
   logic signed [17:0] scaled; // Scaler result for the incoming sample.
   logic s_ok; // Incoming sample addresses a real channel.
   logic p_valid; // Scaled sample waiting for threshold checks.
   logic [1:0] p_chan;
   logic signed [15:0] p_val; // Aligned measurement.
   logic signed [15:0] p_base; // Measurement before alignment.
   logic rise0, fall0, rise1, fall1;
   logic [3:0] raw_causes; // Crossings before masking.
   logic [3:0] cause_hit; // Crossings that become events.
   logic [NUM_CHANNELS-1:0] pending; // Events awaiting issue.
   logic pick_found;
   logic [1:0] pick_chan;
   logic [5:0] pick_num;
   logic wr_ok; // Write addresses a real channel.
   logic lim_ok; // Write data inside user-limit bounds.
   logic signed [16:0] dev; // Required minus measured value.
   logic dev_ok;
   logic [2:0] en_count; // Channels with event processing on.
   logic [SCAN_W-1:0] scan_cnt;
   logic [SCAN_W-1:0] scan_len; // Length of the scan under way.

   assign s_ok = sample.valid && (32'(sample.chan) < NUM_CHANNELS);

   // The scaler sees the configuration of the channel being sampled.
   linear_scaler u_scaler (
      .mode(cfg[sample.chan].mode),
      .user_lo(user_lo[sample.chan]),
      .user_hi(user_hi[sample.chan]),
      .raw(sample.raw),
      .scaled(scaled)
   );

   // Stage one: scale and align. Nothing here waits on writes, so alignment
   // changes take effect on the next sample without a gap.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p_valid <= 1'b0;
         p_chan <= 2'h0;
         p_val <= 16'sh0000;
         p_base <= 16'sh0000;
      end
      else
      begin
         p_valid <= s_ok;
         p_chan <= sample.chan;
         p_base <= sat16(scaled);
         p_val <= sat16(scaled + 18'(offset[sample.chan]));
      end
   end

   // Each new measurement is tested against both thresholds.
   threshold_crossing #(
      .NUM_CHANNELS(NUM_CHANNELS)
   ) u_first (
      .clk(clk),
      .rst_n(rst_n),
      .valid(p_valid),
      .chan(p_chan),
      .value(p_val),
      .threshold(cfg[p_chan].first_threshold),
      .rise(rise0),
      .fall(fall0)
   );

   threshold_crossing #(
      .NUM_CHANNELS(NUM_CHANNELS)
   ) u_second (
      .clk(clk),
      .rst_n(rst_n),
      .valid(p_valid),
      .chan(p_chan),
      .value(p_val),
      .threshold(cfg[p_chan].second_threshold),
      .rise(rise1),
      .fall(fall1)
   );

   // Place the crossings in the cause layout, then gate by mask and enable.
   always_comb
   begin
      raw_causes = 4'h0;
      raw_causes[`CAUSE_RISE0] = rise0;
      raw_causes[`CAUSE_FALL0] = fall0;
      raw_causes[`CAUSE_RISE1] = rise1;
      raw_causes[`CAUSE_FALL1] = fall1;
      cause_hit = raw_causes & cause_mask_word[p_chan][3:0]
         & {4{cfg[p_chan].evt_en}};
   end

   // Measurement words follow every sample; source words only new causes.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < NUM_CHANNELS; c++)
         begin
            meas_word[c] <= 16'h0000;
            base_meas[c] <= 16'sh0000;
            event_source_word[c] <= `SRC_RST;
         end
      end
      else if (p_valid)
      begin
         meas_word[p_chan] <= p_val;
         base_meas[p_chan] <= p_base;
         if (|cause_hit)
            event_source_word[p_chan] <= {12'h000, cause_hit};
      end
   end

   // Lowest event number among pending channels wins; ties take the lower channel.
   always_comb
   begin
      pick_found = 1'b0;
      pick_chan = 2'h0;
      pick_num = 6'h3f;
      for (int c = 0; c < NUM_CHANNELS; c++)
      begin
         if (pending[c] && (!pick_found || cfg[c].evt_num < pick_num))
         begin
            pick_found = 1'b1;
            pick_chan = 2'(c);
            pick_num = cfg[c].evt_num;
         end
      end
   end

   // Pending events: a new cause in the issue cycle keeps the flag set.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pending <= '0;
      else
      begin
         for (int c = 0; c < NUM_CHANNELS; c++)
            pending[c] <= (pending[c] && !(pick_found && 32'(pick_chan) == c))
               || (p_valid && (|cause_hit) && 32'(p_chan) == c);
      end
   end

   // The chosen event goes out as a one-cycle pulse.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         evt <= '0;
      else
      begin
         evt.valid <= pick_found;
         evt.chan <= pick_chan;
         evt.num <= pick_num;
      end
   end

   // Write checks: limits in range, alignment deviation bounded.
   always_comb
   begin
      wr_ok = prog_wr.valid && (32'(prog_wr.chan) < NUM_CHANNELS);
      lim_ok = ($signed(prog_wr.data) >= 16'(-`USER_LIM_MAX))
         && ($signed(prog_wr.data) <= 16'(`USER_LIM_MAX));
      dev = 17'($signed(prog_wr.data)) - 17'(base_meas[prog_wr.chan]);
      dev_ok = (dev >= -17'(`ALIGN_DEV_MAX)) && (dev <= 17'(`ALIGN_DEV_MAX));
   end

   // Mask words, written by the program at any time.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < NUM_CHANNELS; c++)
            cause_mask_word[c] <= `MASK_RST;
      end
      else if (wr_ok && prog_wr.sel == WR_MASK)
         cause_mask_word[prog_wr.chan] <= prog_wr.data;
   end

   // User limits; an out-of-range value leaves the old limit in force.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < NUM_CHANNELS; c++)
         begin
            user_lo[c] <= 16'sh0000;
            user_hi[c] <= 16'(`STD_FULL);
         end
      end
      else if (wr_ok && lim_ok)
      begin
         if (prog_wr.sel == WR_USER_LO)
            user_lo[prog_wr.chan] <= prog_wr.data;
         else if (prog_wr.sel == WR_USER_HI)
            user_hi[prog_wr.chan] <= prog_wr.data;
      end
   end

   // Alignment from the program while running; status bit shows it applied.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < NUM_CHANNELS; c++)
         begin
            offset[c] <= 16'sh0000;
            status_word[c] <= `STATUS_RST;
         end
      end
      else if (wr_ok && prog_wr.sel == WR_ALIGN && dev_ok)
      begin
         offset[prog_wr.chan] <= dev[15:0];
         status_word[prog_wr.chan][`ALIGNED_BIT] <= 1'b1;
      end
      else if (wr_ok && prog_wr.sel == WR_UNALIGN)
      begin
         offset[prog_wr.chan] <= 16'sh0000;
         status_word[prog_wr.chan][`ALIGNED_BIT] <= 1'b0;
      end
   end

   // Refusal pulse for writes that changed nothing.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wr_refused <= 1'b0;
      else
         wr_refused <= prog_wr.valid && (!wr_ok
            || ((prog_wr.sel == WR_USER_LO || prog_wr.sel == WR_USER_HI) && !lim_ok)
            || (prog_wr.sel == WR_ALIGN && !dev_ok)
            || (prog_wr.sel > WR_UNALIGN));
   end

   // Count of channels with event processing on.
   always_comb
   begin
      en_count = 3'h0;
      for (int c = 0; c < NUM_CHANNELS; c++)
         en_count = en_count + 3'(cfg[c].evt_en);
   end

   // Scan timer; the length is fixed at the start so a mid-scan change waits.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scan_cnt <= '0;
         scan_len <= SCAN_W'(SCAN_BASE_CYC);
         scan_start <= 1'b0;
      end
      else if (scan_cnt == scan_len - SCAN_W'(1))
      begin
         scan_cnt <= '0;
         scan_start <= 1'b1;
         scan_len <= SCAN_W'(SCAN_BASE_CYC)
            + SCAN_W'(EVT_EXTRA_CYC) * SCAN_W'(en_count);
      end
      else
      begin
         scan_cnt <= scan_cnt + SCAN_W'(1);
         scan_start <= 1'b0;
      end
   end

   // Helper: cycles since the last scan start, for the period check.
   logic [SCAN_W-1:0] gap;
   logic gap_seen;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap <= '0;
         gap_seen <= 1'b0;
      end
      else if (scan_start)
      begin
         gap <= SCAN_W'(1);
         gap_seen <= 1'b1;
      end
      else
         gap <= gap + SCAN_W'(1);
   end

   a_scan_period: assert property (@(posedge clk) disable iff (!rst_n)
      (scan_start && gap_seen) |-> gap == $past(scan_len))
      else $error("Scan period differs from the programmed length.");

   a_src_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(p_valid && (|cause_hit)) |=> $stable(event_source_word))
      else $error("Source word changed without a new cause.");

   a_src_update: assert property (@(posedge clk) disable iff (!rst_n)
      (p_valid && (|cause_hit)) |=> (event_source_word[$past(p_chan)][3:0]
         & ~$past(cause_mask_word[p_chan][3:0])) == 4'h0 ##1 evt.valid)
      else $error("Masked cause reported or event not raised.");

   a_evt_disabled: assert property (@(posedge clk) disable iff (!rst_n)
      (p_valid && !cfg[p_chan].evt_en) |=> $stable(event_source_word)
         && !(pending[$past(p_chan)] && !$past(pending[p_chan])))
      else $error("Event produced on a disabled channel.");

   a_equal_silent: assert property (@(posedge clk) disable iff (!rst_n)
      (p_valid && p_val == cfg[p_chan].first_threshold) |-> cause_hit[1:0] == 2'b00)
      else $error("Equal measurement raised a first threshold cause.");

   a_align_apply: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_ok && prog_wr.sel == WR_ALIGN && dev_ok) |=>
         status_word[$past(prog_wr.chan)][0] && !wr_refused
         && offset[$past(prog_wr.chan)] == $past(dev[15:0]))
      else $error("Accepted alignment not applied.");

   a_align_refuse: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_ok && prog_wr.sel == WR_ALIGN && !dev_ok) |=> wr_refused && $stable(status_word))
      else $error("Oversized alignment deviation accepted.");

   a_limit_refuse: assert property (@(posedge clk) disable iff (!rst_n)
      (prog_wr.valid && prog_wr.sel == WR_USER_HI && !lim_ok) |=> wr_refused
         && user_hi[$past(prog_wr.chan)] == $past(user_hi[prog_wr.chan]))
      else $error("Out-of-range user limit accepted.");
endmodule

// ### rtl/linear_scaler.sv
`timescale 1ns/10ps
`include "ain_defs.svh"
module linear_scaler (
   // Scaling selection
   input wire ain_pkg::scale_mode_t mode,
   input wire logic signed [15:0] user_lo,
   input wire logic signed [15:0] user_hi,
   // Converter code and result
   input wire logic signed [16:0] raw,
   output logic signed [17:0] scaled
);
   import ain_pkg::*;
   logic signed [17:0] lo; // Value at the range minimum.
   logic signed [17:0] hi; // Value at the range maximum.
   logic signed [17:0] frac; // Position in range, 0 to 2**15.
   logic signed [35:0] prod; // Span times position.

   // Linear map from range minimum to maximum; no clamping, tolerance zones pass through.
   always_comb
   begin
      unique case (mode)
         SCALE_STD_UNI:
         begin
            lo = 18'sh00000;
            hi = 18'(`STD_FULL);
         end
         SCALE_STD_BI:
         begin
            lo = 18'(-`STD_FULL);
            hi = 18'(`STD_FULL);
         end
         SCALE_USER_UNI, SCALE_USER_BI:
         begin
            lo = 18'(user_lo);
            hi = 18'(user_hi);
         end
      endcase
      // A bipolar code spans twice the width, so it is shifted and halved.
      if (mode[0])
         frac = (18'(raw) + 18'(`RAW_HALF)) >>> 1;
      else
         frac = 18'(raw);
      prod = 36'(hi - lo) * 36'(frac);
      scaled = lo + 18'(prod >>> `RAW_SHIFT);
   end
endmodule

// ### rtl/threshold_crossing.sv
`timescale 1ns/10ps
module threshold_crossing #(
   parameter int NUM_CHANNELS = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Measurement under test
   input wire logic valid,
   input wire logic [1:0] chan,
   input wire logic signed [15:0] value,
   input wire logic signed [15:0] threshold,
   // Crossings found
   output logic rise,
   output logic fall
);
   logic [NUM_CHANNELS-1:0] above; // Last strict side per channel.
   logic [NUM_CHANNELS-1:0] known; // A strict side has been seen.

   // A crossing is a strict change of side; equal samples leave the side as it was.
   always_comb
   begin
      rise = valid && known[chan] && !above[chan] && (value > threshold);
      fall = valid && known[chan] && above[chan] && (value < threshold);
   end

   // Remember the side; an equal value neither crosses nor resets it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         above <= '0;
         known <= '0;
      end
      else if (valid && (value != threshold))
      begin
         known[chan] <= 1'b1;
         above[chan] <= (value > threshold);
      end
   end
endmodule

// ### tb/analog_input_threshold_scaling_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module analog_input_threshold_scaling_tb_top;
   import ain_pkg::*;
   logic clk = 1'b0; // Module clock, 25 MHz.
   logic rst_n = 1'b0; // Reset, held low at start.
   sample_t sample = '0; // Converter stream driven by the bench.
   chan_cfg_t [3:0] cfg = '0; // Channel configuration levels.
   prog_wr_t prog_wr;
   logic wr_refused;
   logic [3:0][15:0] meas_word;
   logic [3:0][15:0] event_source_word;
   logic [3:0][15:0] status_word;
   logic [3:0][15:0] cause_mask_word;
   event_t evt;
   logic scan_start;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0; // Cycles run, for the hang guard.
   int evt_cnt = 0; // Events seen.
   event_t last_evt = '0; // Most recent event.
   logic refused;
   int n;

   // Scan counts are shortened so the run stays brief.
   analog_input_threshold_scaling #(.NUM_CHANNELS(4), .SCAN_BASE_CYC(50), .EVT_EXTRA_CYC(10)) DUT (
      .clk(clk), .rst_n(rst_n), .sample(sample), .cfg(cfg), .prog_wr(prog_wr),
      .wr_refused(wr_refused), .meas_word(meas_word), .event_source_word(event_source_word),
      .status_word(status_word), .cause_mask_word(cause_mask_word), .evt(evt),
      .scan_start(scan_start));
   ctrl_model u_ctrl (.clk(clk), .prog_wr(prog_wr), .wr_refused(wr_refused));

   // Half period of 20 ns.
   always #20 clk = ~clk;

   // Events are one-cycle pulses, so the falling edge sees each one settled.
   always @(negedge clk)
      if (evt.valid === 1'b1)
      begin
         evt_cnt++;
         last_evt = evt;
      end

   // Hang guard: the tests need far fewer cycles than this.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   // Prints the counts and the verdict, then stops.
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One sample, then wait past the word and event latencies.
   task send(input logic [1:0] ch, input logic signed [16:0] raw);
      @(posedge clk);
      #1;
      sample = '{valid: 1'b1, chan: ch, raw: raw};
      @(posedge clk);
      #1;
      sample.valid = 1'b0;
      sample.raw = ~raw;
      repeat (4) @(posedge clk);
      #1;
   endtask

   // One program write and a check of whether it was refused.
   task wr(input wr_sel_t sel, input logic [1:0] ch, input logic [15:0] d, input logic ex);
      u_ctrl.write(sel, ch, d, refused);
      `CHK("refused", ex, refused)
   endtask

   // Words after reset.
   task t_reset;
      `CHK("mask rst", 16'h0000, cause_mask_word[0])
      `CHK("source rst", 16'h0000, event_source_word[0])
      `CHK("status rst", 16'h0000, status_word[1])
      $display("test reset done");
   endtask

   // Crossings, masking, holding and enable on channel 0, then a rise on channel 3 (thresholds 5000 and 7500).
   task t_cross;
      cfg[0] = '{1'b1, 6'h05, SCALE_STD_UNI, 16'sd5000, 16'sd7500};
      wr(WR_MASK, 2'd0, 16'h000f, 1'b0);
      `CHK("mask rb", 16'h000f, cause_mask_word[0])
      send(2'd0, 17'sd8192);
      `CHK("meas", 16'(2500), meas_word[0])
      `CHK("src first", 16'h0000, event_source_word[0])
      send(2'd0, 17'sd16384);
      `CHK("src equal", 16'h0000, event_source_word[0])
      `CHK("evt equal", 0, evt_cnt)
      send(2'd0, 17'sd20480);
      `CHK("src rise0", 16'h0001, event_source_word[0])
      `CHK("evt rise0", 1, evt_cnt)
      `CHK("evt num", 6'h05, last_evt.num)
      send(2'd0, 17'sd20480);
      `CHK("src hold", 16'h0001, event_source_word[0])
      send(2'd0, 17'sd28672);
      `CHK("src rise1", 16'h0004, event_source_word[0])
      send(2'd0, 17'sd8192);
      `CHK("src falls", 16'h000a, event_source_word[0])
      `CHK("evt falls", 3, evt_cnt)
      wr(WR_MASK, 2'd0, 16'h000b, 1'b0);
      send(2'd0, 17'sd28672);
      `CHK("src masked", 16'h0001, event_source_word[0])
      wr(WR_MASK, 2'd0, 16'h0000, 1'b0);
      send(2'd0, 17'sd8192);
      `CHK("src all masked", 16'h0001, event_source_word[0])
      `CHK("evt all masked", 4, evt_cnt)
      cfg[0].evt_en = 1'b0;
      wr(WR_MASK, 2'd0, 16'h000f, 1'b0);
      send(2'd0, 17'sd28672);
      `CHK("evt disabled", 4, evt_cnt)
      // A second channel with its own number, so the event's channel field is exercised.
      cfg[3] = '{1'b1, 6'h02, SCALE_STD_UNI, 16'sd5000, 16'sd7500};
      wr(WR_MASK, 2'd3, 16'h0001, 1'b0);
      send(2'd3, 17'sd8192);
      send(2'd3, 17'sd20480);
      `CHK("evt chan", 2'd3, last_evt.chan)
      `CHK("evt num ch3", 6'h02, last_evt.num)
      `CHK("src ch3", 16'h0001, event_source_word[3])
      `CHK("evt count ch3", 5, evt_cnt)
      cfg[3].evt_en = 1'b0;
      $display("test cross done");
   endtask

   // Every scaling mode: standard ranges at both ends, user unipolar at its top, user bipolar at mid-range, then the user limits.
   task automatic t_scale;
      scale_mode_t md[6] = '{SCALE_STD_UNI, SCALE_STD_UNI, SCALE_STD_BI, SCALE_STD_BI,
                            SCALE_USER_UNI, SCALE_USER_BI};
      int rw[6] = '{0, 32768, -32768, 32768, 32768, 0};
      int ex[6] = '{0, 10000, -10000, 10000, 9600, 6400};
      wr(WR_USER_LO, 2'd2, 16'(3200), 1'b0);
      wr(WR_USER_HI, 2'd2, 16'(9600), 1'b0);
      for (int i = 0; i < 6; i++)
      begin
         cfg[2].mode = md[i];
         send(2'd2, 17'(rw[i]));
         `CHK("scaled", 16'(ex[i]), meas_word[2])
      end
      wr(WR_USER_LO, 2'd2, 16'(30001), 1'b1);
      wr(WR_USER_HI, 2'd2, 16'(-30001), 1'b1);
      wr(WR_USER_LO, 2'd2, 16'(-30000), 1'b0);
      cfg[2].mode = SCALE_USER_UNI;
      send(2'd2, 17'sd0);
      `CHK("user lo", 16'(-30000), meas_word[2])
      $display("test scale done");
   endtask

   // Alignment applied, refused beyond the deviation, and removed.
   task t_align;
      cfg[1].mode = SCALE_STD_UNI;
      send(2'd1, 17'sd16384);
      wr(WR_ALIGN, 2'd1, 16'(5010), 1'b0);
      `CHK("aligned", 16'h0001, status_word[1])
      send(2'd1, 17'sd16384);
      `CHK("meas aligned", 16'(5010), meas_word[1])
      wr(WR_ALIGN, 2'd1, 16'(6500), 1'b1);
      wr(wr_sel_t'(3'h5), 2'd1, 16'h0000, 1'b1);
      `CHK("still aligned", 16'h0001, status_word[1])
      wr(WR_UNALIGN, 2'd1, 16'h0000, 1'b0);
      `CHK("unaligned", 16'h0000, status_word[1])
      send(2'd1, 17'sd16384);
      `CHK("meas plain", 16'(5000), meas_word[1])
      $display("test align done");
   endtask

   // Cycles from one scan start to the next.
   task gap(output int c);
      int k;
      k = 0;
      while (scan_start !== 1'b1 && k < 500)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      @(posedge clk);
      #1;
      c = 1;
      while (scan_start !== 1'b1 && c < 500)
      begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask

   // Scan length with none, one and two channels processing events.
   task t_scan;
      for (int e = 0; e < 3; e++)
      begin
         for (int c = 0; c < 4; c++)
            cfg[c].evt_en = (c == 0 && e > 0) || (c == 3 && e > 1);
         gap(n);
         gap(n);
         `CHK("scan", 50 + 10 * e, n)
      end
      $display("test scan done");
   endtask

   // Reset for two cycles, then the scenarios in turn.
   initial
   begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_cross();
      t_scale();
      t_align();
      t_scan();
      end_of_test();
   end
endmodule

// ### tb/ctrl_model.sv
`timescale 1ns/10ps
module ctrl_model (
   // Clock
   input wire logic clk,
   // Write port toward the module
   output ain_pkg::prog_wr_t prog_wr,
   input wire logic wr_refused
);
   import ain_pkg::*;
   // The port idles with valid low.
   initial prog_wr = '0;
   // One program write, with the answer gathered from the cycles after the take.
   task automatic write(input wr_sel_t sel, input logic [1:0] ch,
                        input logic [15:0] data, output logic refused);
      @(posedge clk);
      #1;
      prog_wr = '{valid: 1'b1, sel: sel, chan: ch, data: data};
      @(posedge clk);
      #1;
      refused = wr_refused;
      prog_wr.valid = 1'b0;
      // Stale data is inverted so that it never passes for a fresh write.
      prog_wr.data = ~data;
      @(posedge clk);
      #1;
      refused = refused | wr_refused;
   endtask
endmodule
